//--- hdl/rtcti_timebase.sv
// Module: real-time timebase counters with interval compare, on a byte register port
// Functional notes
// RULE_01: Match flag sets when interval counter equals the compare register.
// RULE_02: Interrupt request raised on match only when interval interrupt enabled.
// RULE_03: Software writes interval length 0 to 255 into the compare register.
// RULE_04: Fraction counter ticks every 1/128 s, 0..127, wrap increments seconds.
// RULE_05: Seconds count 0..59, wrap increments minutes.
// RULE_06: Minutes count 0..59, wrap increments hours.
// RULE_07: Hours count 0..23 then wrap to 0 with no carry.
// RULE_08: Timebase counters advance only while time clock enable is set.
// RULE_09: Warm reset keeps counters if time clock enabled, else clears them.
// RULE_10: Power-on reset zeroes all counters and the compare register.
// RULE_11: Interval counter steps on selected overflow; compare after each step.
// RULE_12: Two-bit select picks fraction, seconds, minutes or hours overflow.
// RULE_13: Single-shot timeout clears count enable; else counter restarts.
// RULE_14: Clearing interval count enable stops and zeroes the interval counter.
// RULE_15: Time counter writes accepted only while time clock enable is clear.
`timescale 1ns/1ps
`default_nettype none
module rtcti_timebase
#(
   parameter longint TICK_CYCLES = rtcti_pkg::TICK_CYCLES_DEFAULT
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SYS_RST_B,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   output logic [7:0] SFR_RDATA,
   input wire logic INTERVAL_IRQ_ENABLE,
   output logic INTERVAL_IRQ
);
   import rtcti_pkg::*;

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic time_clock_enable, interval_count_enable, interval_match_flag;
   logic single_shot_select, timebase_select_high, timebase_select_low;
   logic [7:0] interval_compare_value;
   logic [7:0] interval_count;
   logic [PRESCALE_W-1:0] prescale;
   logic [7:0] fraction_tick_counter, whole_second_counter;
   logic [7:0] sixty_second_counter, day_segment_counter;
   logic wrap_fraction, wrap_second, wrap_minute;
   logic tick, warm_reset, time_clear, time_write_ok, ctrl_write;
   logic selected_wrap, interval_step, interval_timeout;
   logic [7:0] next_interval_count;
   rtcti_sel_t sel;

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
      hit = (addr == target);
   endfunction

   assign warm_reset = !SYS_RST_B;
   assign ctrl_write = SFR_WR && hit(SFR_ADDR, ADDR_TICK_CONTROL);
   assign time_clear = warm_reset && !time_clock_enable; // RULE_09
   assign time_write_ok = SFR_WR && !time_clock_enable; // RULE_15
   assign sel = rtcti_sel_t'({timebase_select_high, timebase_select_low});

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         time_clock_enable <= 1'b0; // RULE_10
      end
      else if (ctrl_write && !warm_reset)
      begin
         time_clock_enable <= SFR_WDATA[BIT_TIME_CLOCK_EN];
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         single_shot_select <= 1'b0;
         timebase_select_high <= 1'b0;
         timebase_select_low <= 1'b0;
      end
      else if (warm_reset)
      begin
         single_shot_select <= 1'b0;
         timebase_select_high <= 1'b0;
         timebase_select_low <= 1'b0;
      end
      else if (ctrl_write)
      begin
         single_shot_select <= SFR_WDATA[BIT_SINGLE_SHOT];
         timebase_select_high <= SFR_WDATA[BIT_SEL_HIGH]; // RULE_12
         timebase_select_low <= SFR_WDATA[BIT_SEL_LOW]; // RULE_12
      end
   end

   // Count enable: single-shot timeout wins over a same-cycle write
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         interval_count_enable <= 1'b0;
      end
      else if (warm_reset)
      begin
         interval_count_enable <= 1'b0;
      end
      else if (interval_timeout && single_shot_select)
      begin
         interval_count_enable <= 1'b0; // RULE_13
      end
      else if (ctrl_write)
      begin
         interval_count_enable <= SFR_WDATA[BIT_COUNT_EN];
      end
   end

   // Match flag: a match in the clearing cycle still sets it
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         interval_match_flag <= 1'b0;
      end
      else if (warm_reset)
      begin
         interval_match_flag <= 1'b0;
      end
      else if (interval_timeout)
      begin
         interval_match_flag <= 1'b1; // RULE_01
      end
      else if (ctrl_write)
      begin
         interval_match_flag <= SFR_WDATA[BIT_MATCH_FLAG];
      end
   end

   // ----------------------------------------
   // Compare register
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         interval_compare_value <= REG_RESET; // RULE_10
      end
      else if (warm_reset)
      begin
         interval_compare_value <= REG_RESET;
      end
      else if (SFR_WR && hit(SFR_ADDR, ADDR_COMPARE))
      begin
         interval_compare_value <= SFR_WDATA;
      end
   end

   // ----------------------------------------
   // Prescaler to 1/128 second ticks
   // ----------------------------------------
   assign tick = time_clock_enable
      && (prescale == PRESCALE_W'(TICK_CYCLES - 1)); // RULE_04

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         prescale <= '0;
      end
      else if (!time_clock_enable || tick)
      begin
         prescale <= '0; // RULE_08
      end
      else
      begin
         prescale <= prescale + PRESCALE_W'(1);
      end
   end

   // ----------------------------------------
   // Time counters
   // ----------------------------------------
   rtcti_mod_counter u_fraction
   (
      .clk(CLK), .rst_b(RST_B), .clear(time_clear), .step(tick), .max_value(FRACTION_MAX),
      .load(time_write_ok && hit(SFR_ADDR, ADDR_FRACTION)), .load_value(SFR_WDATA),
      .count(fraction_tick_counter), .wrap(wrap_fraction)
   ); // RULE_04

   rtcti_mod_counter u_second
   (
      .clk(CLK), .rst_b(RST_B), .clear(time_clear), .step(wrap_fraction), .max_value(SECOND_MAX),
      .load(time_write_ok && hit(SFR_ADDR, ADDR_SECOND)), .load_value(SFR_WDATA),
      .count(whole_second_counter), .wrap(wrap_second)
   ); // RULE_05

   rtcti_mod_counter u_minute
   (
      .clk(CLK), .rst_b(RST_B), .clear(time_clear), .step(wrap_second), .max_value(MINUTE_MAX),
      .load(time_write_ok && hit(SFR_ADDR, ADDR_MINUTE)), .load_value(SFR_WDATA),
      .count(sixty_second_counter), .wrap(wrap_minute)
   ); // RULE_06

   rtcti_mod_counter u_hour
   (
      .clk(CLK), .rst_b(RST_B), .clear(time_clear), .step(wrap_minute), .max_value(HOUR_MAX),
      .load(time_write_ok && hit(SFR_ADDR, ADDR_HOUR)), .load_value(SFR_WDATA),
      .count(day_segment_counter), .wrap()
   ); // RULE_07

   // ----------------------------------------
   // Interval counter and compare
   // ----------------------------------------
   always_comb
   begin
      case (sel)
         RTCTI_SEL_FRACTION: selected_wrap = tick; // RULE_12
         RTCTI_SEL_SECOND: selected_wrap = wrap_fraction;
         RTCTI_SEL_MINUTE: selected_wrap = wrap_second;
         default: selected_wrap = wrap_minute;
      endcase
   end

   assign interval_step = interval_count_enable && !warm_reset && selected_wrap; // RULE_11
   assign next_interval_count = interval_count + COUNT_STEP;
   assign interval_timeout = interval_step
      && (next_interval_count == interval_compare_value); // RULE_01

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         interval_count <= REG_RESET;
      end
      else if (!interval_count_enable || warm_reset || interval_timeout)
      begin
         interval_count <= REG_RESET; // RULE_14
      end
      else if (interval_step)
      begin
         interval_count <= next_interval_count; // RULE_11
      end
   end

   // ----------------------------------------
   // Interrupt request and read port
   // ----------------------------------------
   assign INTERVAL_IRQ = interval_match_flag && INTERVAL_IRQ_ENABLE; // RULE_02

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         SFR_RDATA <= REG_RESET;
      end
      else if (SFR_RD)
      begin
         if (hit(SFR_ADDR, ADDR_TICK_CONTROL))
         begin
            SFR_RDATA <= {2'b00, timebase_select_high, timebase_select_low,
               single_shot_select, interval_match_flag, interval_count_enable,
               time_clock_enable};
         end
         else if (hit(SFR_ADDR, ADDR_FRACTION))
         begin
            SFR_RDATA <= fraction_tick_counter;
         end
         else if (hit(SFR_ADDR, ADDR_SECOND))
         begin
            SFR_RDATA <= whole_second_counter;
         end
         else if (hit(SFR_ADDR, ADDR_MINUTE))
         begin
            SFR_RDATA <= sixty_second_counter;
         end
         else if (hit(SFR_ADDR, ADDR_HOUR))
         begin
            SFR_RDATA <= day_segment_counter;
         end
         else if (hit(SFR_ADDR, ADDR_COMPARE))
         begin
            SFR_RDATA <= interval_compare_value;
         end
         else
         begin
            SFR_RDATA <= REG_RESET;
         end
      end
   end
endmodule
`default_nettype wire

//--- hdl/rtcti_pkg.sv
// Package: register map, field layout and timing constants of the timebase block
package rtcti_pkg;
   // Register map
   localparam logic [7:0] ADDR_TICK_CONTROL = 8'hA1;
   localparam logic [7:0] ADDR_FRACTION = 8'hA2;
   localparam logic [7:0] ADDR_SECOND = 8'hA3;
   localparam logic [7:0] ADDR_MINUTE = 8'hA4;
   localparam logic [7:0] ADDR_HOUR = 8'hA5;
   localparam logic [7:0] ADDR_COMPARE = 8'hA6;
   // Control register field positions
   localparam int BIT_TIME_CLOCK_EN = 0;
   localparam int BIT_COUNT_EN = 1;
   localparam int BIT_MATCH_FLAG = 2;
   localparam int BIT_SINGLE_SHOT = 3;
   localparam int BIT_SEL_LOW = 4;
   localparam int BIT_SEL_HIGH = 5;
   // Reset values and counter limits
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] FRACTION_MAX = 8'h7F;
   localparam logic [7:0] SECOND_MAX = 8'h3B;
   localparam logic [7:0] MINUTE_MAX = 8'h3B;
   localparam logic [7:0] HOUR_MAX = 8'h17;
   localparam logic [7:0] COUNT_STEP = 8'h01;
   // Timebase selection codes
   typedef enum logic [1:0]
   {
      RTCTI_SEL_FRACTION = 2'h0,
      RTCTI_SEL_SECOND = 2'h1,
      RTCTI_SEL_MINUTE = 2'h2,
      RTCTI_SEL_HOUR = 2'h3
   } rtcti_sel_t;
   // Timing: one tick is 1/128 s, clock is 25 MHz
   localparam longint CLK_HZ = 25000000;
   localparam longint TICKS_PER_SECOND = 128;
   localparam longint TICK_CYCLES_DEFAULT = CLK_HZ / TICKS_PER_SECOND;
   localparam int PRESCALE_W = 18;
endpackage

//--- hdl/rtcti_mod_counter.sv
// Module: 8-bit modulo counter with wrap strobe, load and clear
`timescale 1ns/1ps
`default_nettype none
module rtcti_mod_counter
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic load,
   input wire logic [7:0] load_value,
   input wire logic step,
   input wire logic [7:0] max_value,
   output logic [7:0] count,
   output logic wrap
);
   import rtcti_pkg::*;

   assign wrap = step && (count == max_value);

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count <= REG_RESET;
      end
      else if (clear)
      begin
         count <= REG_RESET;
      end
      else if (load)
      begin
         count <= load_value;
      end
      else if (step)
      begin
         if (wrap)
         begin
            count <= REG_RESET;
         end
         else
         begin
            count <= count + COUNT_STEP;
         end
      end
   end
endmodule
`default_nettype wire

//--- verification/rtcti_timebase_sva.sv
// Checker: port-level properties of the timebase block
`timescale 1ns/1ps
`default_nettype none
module rtcti_timebase_chk
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SYS_RST_B,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_WDATA,
   input wire logic [7:0] SFR_RDATA,
   input wire logic INTERVAL_IRQ_ENABLE,
   input wire logic INTERVAL_IRQ
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   a_irq_needs_en: assert property (INTERVAL_IRQ |-> INTERVAL_IRQ_ENABLE)
      else $error("request without enable");
   a_flag_stays_set: assert property (INTERVAL_IRQ && !SFR_WR && SYS_RST_B ##1
      INTERVAL_IRQ_ENABLE |-> INTERVAL_IRQ)
      else $error("request dropped on its own");
   a_fraction_range: assert property (SFR_RD && SFR_ADDR == 8'hA2 |=> SFR_RDATA <= 8'h7F)
      else $error("fraction above range");
   a_second_range: assert property (SFR_RD && SFR_ADDR == 8'hA3 |=> SFR_RDATA <= 8'h3B)
      else $error("seconds above range");
   a_minute_range: assert property (SFR_RD && SFR_ADDR == 8'hA4 |=> SFR_RDATA <= 8'h3B)
      else $error("minutes above range");
   a_hour_range: assert property (SFR_RD && SFR_ADDR == 8'hA5 |=> SFR_RDATA <= 8'h17)
      else $error("hours above range");
   a_compare_kept: assert property (SFR_WR && SFR_ADDR == 8'hA6 && SYS_RST_B ##1
      SFR_RD && SFR_ADDR == 8'hA6 && SYS_RST_B |=> SFR_RDATA == $past(SFR_WDATA, 2))
      else $error("compare value not kept");
   a_por_clear: assert property (disable iff (1'b0) !RST_B |->
      SFR_RDATA == 8'h00 && !INTERVAL_IRQ)
      else $error("outputs not cleared in reset");
   c_irq: cover property ($rose(INTERVAL_IRQ));
   c_warm: cover property (!SYS_RST_B);
   c_hour_read: cover property (SFR_RD && SFR_ADDR == 8'hA5);
endmodule
`default_nettype wire

//--- verification/rtcti_core_model.sv
// Partner: core-side interrupt enable register
`timescale 1ns/1ps
`default_nettype none
module rtcti_core_model
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic set_enable,
   output logic irq_enable
);
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         irq_enable <= 1'b0;
      else
         irq_enable <= set_enable;
   end
endmodule
`default_nettype wire

//--- verification/test_rtcti_timebase.sv
// Testbench: register-level scenarios for the timebase block
`timescale 1ns/1ps
`default_nettype none
module test_rtcti_timebase;
   import rtcti_pkg::*;
   logic clk, rst_b, sys_rst_b, wr_en, rd_en, want_en, irq_en, irq;
   logic [7:0] addr, wdata, rdata;
   int error_cnt, comparisons;
   rtcti_timebase #(.TICK_CYCLES(4)) uut (.CLK(clk), .RST_B(rst_b), .SYS_RST_B(sys_rst_b),
      .SFR_ADDR(addr), .SFR_WR(wr_en), .SFR_RD(rd_en), .SFR_WDATA(wdata),
      .SFR_RDATA(rdata), .INTERVAL_IRQ_ENABLE(irq_en), .INTERVAL_IRQ(irq));
   rtcti_core_model pm (.clk(clk), .rst_b(rst_b), .set_enable(want_en), .irq_enable(irq_en));
   // ------
   // Tasks
   // ------
   task automatic print_verdict();
      $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Idle wait drops both strobes
   task automatic cyc(input int n);
      wr_en = 1'b0;
      rd_en = 1'b0;
      repeat (n) @(negedge clk);
   endtask
   // Strobe stays up until the next access or idle wait
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      rd_en = 1'b0;
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      wr_en = 1'b0;
      addr = a;
      rd_en = 1'b1;
      @(negedge clk);
      chk(rdata, e);
   endtask
   task automatic set_time(input logic [7:0] f, s, m, h);
      wr(ADDR_FRACTION, f);
      wr(ADDR_SECOND, s);
      wr(ADDR_MINUTE, m);
      wr(ADDR_HOUR, h);
   endtask
   task automatic chk_time(input logic [7:0] f, s, m, h);
      rd(ADDR_FRACTION, f);
      rd(ADDR_SECOND, s);
      rd(ADDR_MINUTE, m);
      rd(ADDR_HOUR, h);
   endtask
   // Runs the time clock for exactly one tick
   task automatic tick1();
      wr(ADDR_TICK_CONTROL, 8'h01);
      wr(ADDR_HOUR, 8'h05);
      cyc(4);
      wr(ADDR_TICK_CONTROL, 8'h00);
   endtask
   task automatic wait_irq(input int n);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < n)
      begin
         cyc(1);
         k++;
      end
      chk({7'h00, irq}, 8'h01);
      if (irq !== 1'b1)
      begin
         print_verdict();
      end
   endtask
   // ------
   // Sequence
   // ------
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      rst_b = 1'b0;
      sys_rst_b = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      want_en = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      cyc(3);
      rst_b = 1'b1;
      for (int i = 0; i < 7; i++)
         rd(8'hA0 + 8'(i), 8'h00);
      set_time(8'h7F, 8'h3B, 8'h3B, 8'h16);
      tick1();
      chk_time(8'h00, 8'h00, 8'h00, 8'h17);
      set_time(8'h7F, 8'h3B, 8'h3B, 8'h17);
      tick1();
      cyc(12);
      chk_time(8'h00, 8'h00, 8'h00, 8'h00);
      wr(ADDR_TICK_CONTROL, 8'h01);
      cyc(13);
      wr(ADDR_TICK_CONTROL, 8'h00);
      rd(ADDR_FRACTION, 8'h03);
      // Warm reset with the time clock off, then on
      wr(ADDR_FRACTION, 8'h05);
      wr(ADDR_COMPARE, 8'h09);
      rd(ADDR_COMPARE, 8'h09);
      sys_rst_b = 1'b0;
      cyc(1);
      sys_rst_b = 1'b1;
      rd(ADDR_FRACTION, 8'h00);
      rd(ADDR_COMPARE, 8'h00);
      wr(ADDR_SECOND, 8'h07);
      wr(ADDR_TICK_CONTROL, 8'h01);
      sys_rst_b = 1'b0;
      cyc(1);
      sys_rst_b = 1'b1;
      rd(ADDR_TICK_CONTROL, 8'h01);
      wr(ADDR_TICK_CONTROL, 8'h00);
      rd(ADDR_SECOND, 8'h07);
      // Single-shot match with the core enable off, then on
      wr(ADDR_COMPARE, 8'h01);
      wr(ADDR_TICK_CONTROL, 8'h0B);
      cyc(12);
      chk({7'h00, irq}, 8'h00);
      rd(ADDR_TICK_CONTROL, 8'h0D);
      want_en = 1'b1;
      cyc(2);
      chk({7'h00, irq}, 8'h01);
      wr(ADDR_TICK_CONTROL, 8'h00);
      chk({7'h00, irq}, 8'h00);
      for (int s = 0; s < 4; s++)
      begin
         set_time(8'h7E, 8'h3B, 8'h3B, 8'h17);
         wr(ADDR_TICK_CONTROL, {2'b00, s[1:0], 4'hB});
         cyc(4);
         chk({7'h00, irq}, (s == 0) ? 8'h01 : 8'h00);
         wait_irq(20);
         rd(ADDR_TICK_CONTROL, {2'b00, s[1:0], 4'hD});
         wr(ADDR_TICK_CONTROL, 8'h00);
      end
      // Periodic mode; count enable low clears the interval counter
      wr(ADDR_COMPARE, 8'h02);
      wr(ADDR_TICK_CONTROL, 8'h03);
      cyc(4);
      wr(ADDR_TICK_CONTROL, 8'h01);
      wr(ADDR_TICK_CONTROL, 8'h03);
      cyc(4);
      chk({7'h00, irq}, 8'h00);
      wait_irq(20);
      rd(ADDR_TICK_CONTROL, 8'h07);
      wr(ADDR_TICK_CONTROL, 8'h00);
      print_verdict();
   end
endmodule
bind rtcti_timebase rtcti_timebase_chk chk (.CLK(CLK), .RST_B(RST_B), .SYS_RST_B(SYS_RST_B),
   .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
   .SFR_RDATA(SFR_RDATA), .INTERVAL_IRQ_ENABLE(INTERVAL_IRQ_ENABLE),
   .INTERVAL_IRQ(INTERVAL_IRQ));
`default_nettype wire
